//--- rtl/eeprom_ctl_pkg.sv
// eeprom control package: register map, field positions, reset values,
// timing counts and the state record of the control block.
// assumes a 100 MHz bus clock and an apb slave at 32-bit data.
package eeprom_ctl_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [15:0] MCR_ADDR = 16'h0000;
    localparam logic [15:0] PROT_ADDR = 16'h0004;
    localparam logic [15:0] PROG_ADDR = 16'h0008;
    localparam logic [15:0] DIVH_ADDR = 16'h000c;
    localparam logic [15:0] DIVL_ADDR = 16'h0010;
    // array window: paddr[14] set, byte offset in paddr[13:2]
    localparam int ARRAY_SEL_BIT = 14;
    localparam logic [11:0] SHADOW_HI_OFS = 12'hfc0;
    localparam logic [11:0] SHADOW_LO_OFS = 12'hfc1;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MCR_DBG_LOCK_DIS = 7;
    localparam int MCR_SHADOW_DIS = 6;
    localparam int MCR_PROT_LOCK = 1;
    localparam int PROG_BULK_PROT = 7;
    localparam int PROG_AUTO = 5;
    localparam int PROG_ONE_LOC = 4;
    localparam int PROG_ROW = 3;
    localparam int PROG_ERASE = 2;
    localparam int PROG_LATCH = 1;
    localparam int PROG_PGM = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MCR_RST = 8'hfc;
    localparam logic [7:0] PROT_RST = 8'hff;
    localparam logic [7:0] PROG_RST = 8'h80;
    localparam logic [9:0] DIV_RST = 10'h000;
    localparam logic [7:0] MCR_FIXED_ONES = 8'h08;

    // ------------------------------------------------------------
    // timing: divided oscillator tick of 35 us, program time 10 ms
    // ------------------------------------------------------------
    localparam int PROGRAM_TIME_US = 10000;
    localparam int DIV_TICK_NS = 35000;
    localparam int HV_TICKS =
        (PROGRAM_TIME_US * 1000 + DIV_TICK_NS - 1) / DIV_TICK_NS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_LD_HI = 2'b00,
        ST_LD_LO = 2'b01,
        ST_RUN = 2'b10
    } ld_state_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [15:0] wdata;
        logic word;
        logic shadow;
        logic hv;
        logic erase;
        logic one_loc;
        logic row;
    } array_port_t;

    typedef struct packed {
        ld_state_t st;
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
        logic smn_s1;
        logic smn_s2;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] mcr;
        logic [7:0] prot;
        logic [7:0] prog;
        logic [9:0] div;
        logic [1:0] div_locked;
        logic [9:0] presc;
        logic [8:0] hv_cnt;
        array_port_t arr;
    } ctl_state_t;

endpackage : eeprom_ctl_pkg

//--- rtl/eeprom_ctl.sv
// eeprom control block: apb registers, program/erase sequencing,
// shadow word load at reset and clock divider, write-once in normal mode only.
// assumes a byte-wide array behind arr with combinational read of arr_rdata.
`timescale 1ns/1ps

module eeprom_ctl
    import eeprom_ctl_pkg::*;
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic osc_clk,
    input wire logic special_mode_n,
    output logic debug_lockout_disable,
    // array
    input wire logic [7:0] arr_rdata,
    output array_port_t arr
);

    ctl_state_t s;
    ctl_state_t n;

    function automatic logic shadow_hit(input logic [11:0] ofs,
                                        input logic dis);
        shadow_hit = !dis && (ofs[11:1] == SHADOW_HI_OFS[11:1]);
    endfunction : shadow_hit

    logic setup;
    logic access;
    logic commit;
    logic is_array;
    logic [11:0] ofs;
    logic tick;
    logic normal;
    logic pgm;

    assign setup = psel && !penable;
    assign access = psel && penable && !s.pready;
    assign commit = psel && penable && s.pready;
    assign is_array = paddr[ARRAY_SEL_BIT];
    assign ofs = paddr[13:2];
    assign tick = s.osc_s2 && !s.osc_s3;
    assign normal = s.smn_s2;
    assign pgm = s.prog[PROG_PGM];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.osc_s1 = osc_clk;
        n.osc_s2 = s.osc_s1;
        n.osc_s3 = s.osc_s2;
        n.smn_s1 = special_mode_n;
        n.smn_s2 = s.smn_s1;
        n.pready = 1'b0;
        unique case (s.st)
            ST_LD_HI: begin
                // bits 7:4 to config, 1:0 to divider high
                n.mcr[7:4] = arr_rdata[7:4];
                n.div[9:8] = arr_rdata[1:0];
                n.arr.addr = SHADOW_LO_OFS;
                n.st = ST_LD_LO;
            end
            ST_LD_LO: begin
                n.div[7:0] = arr_rdata;
                n.arr.shadow = 1'b0;
                n.st = ST_RUN;
            end
            ST_RUN: begin
                // address phase reaches the array unless latched
                if (setup && is_array && !s.prog[PROG_LATCH]) begin
                    n.arr.addr = ofs;
                    n.arr.shadow = shadow_hit(ofs, s.mcr[MCR_SHADOW_DIS]);
                end
                if (access) begin
                    n.pready = 1'b1;
                    n.pslverr = 1'b0;
                    n.prdata = 32'h0000_0000;
                    if (is_array) begin
                        n.prdata[7:0] = arr_rdata;
                    end else begin
                        unique case (paddr)
                            MCR_ADDR: n.prdata[7:0] = s.mcr | MCR_FIXED_ONES;
                            PROT_ADDR: n.prdata[7:0] = s.prot;
                            PROG_ADDR: n.prdata[7:0] = s.prog;
                            DIVH_ADDR: n.prdata[1:0] = s.div[9:8];
                            DIVL_ADDR: n.prdata[7:0] = s.div[7:0];
                            default: n.pslverr = 1'b1;
                        endcase
                    end
                end
                if (commit && pwrite && pstrb[0]) begin
                    if (is_array) begin
                        // array write lands in the latches
                        if (s.prog[PROG_LATCH] && !pgm) begin
                            n.arr.addr = ofs;
                            n.arr.shadow =
                                shadow_hit(ofs, s.mcr[MCR_SHADOW_DIS]);
                            n.arr.word = pstrb[1] && !ofs[0];
                            n.arr.wdata = pstrb[1] && !ofs[0] ?
                                pwdata[15:0] : {8'h00, pwdata[7:0]};
                        end
                    end else begin
                        unique case (paddr)
                            MCR_ADDR: begin
                                if (!normal) begin
                                    n.mcr[7:4] = pwdata[7:4];
                                    n.mcr[MCR_PROT_LOCK] =
                                        pwdata[MCR_PROT_LOCK];
                                end else if (pwdata[MCR_PROT_LOCK]) begin
                                    n.mcr[MCR_PROT_LOCK] = 1'b1;
                                end
                                n.mcr[2] = pwdata[2];
                                n.mcr[0] = pwdata[0];
                            end
                            PROT_ADDR: begin
                                if (!pgm && !s.mcr[MCR_PROT_LOCK]) begin
                                    n.prot = pwdata[7:0] | 8'h40;
                                end
                            end
                            PROG_ADDR: begin
                                if (pgm) begin
                                    if (!pwdata[PROG_PGM]) begin
                                        n.prog[PROG_PGM] = 1'b0;
                                        n.arr.hv = 1'b0;
                                    end
                                end else begin
                                    if (!s.mcr[MCR_PROT_LOCK]) begin
                                        n.prog[PROG_BULK_PROT] =
                                            pwdata[PROG_BULK_PROT];
                                    end
                                    n.prog[PROG_AUTO] = pwdata[PROG_AUTO];
                                    n.prog[PROG_ONE_LOC] =
                                        pwdata[PROG_ONE_LOC];
                                    n.prog[PROG_ROW] = pwdata[PROG_ROW];
                                    n.prog[PROG_ERASE] = pwdata[PROG_ERASE];
                                    if (s.div != 10'h000) begin
                                        n.prog[PROG_LATCH] =
                                            pwdata[PROG_LATCH];
                                    end
                                    if (pwdata[PROG_PGM] &&
                                        s.prog[PROG_LATCH] &&
                                        pwdata[PROG_LATCH] &&
                                        s.div != 10'h000) begin
                                        n.prog[PROG_PGM] = 1'b1;
                                        n.arr.hv = 1'b1;
                                        n.presc = 10'h000;
                                        n.hv_cnt = 9'h000;
                                    end
                                end
                            end
                            DIVH_ADDR: begin
                                if (!s.div_locked[1] || !normal) begin
                                    n.div[9:8] = pwdata[1:0];
                                    n.div_locked[1] = normal;
                                end
                            end
                            DIVL_ADDR: begin
                                if (!s.div_locked[0] || !normal) begin
                                    n.div[7:0] = pwdata[7:0];
                                    n.div_locked[0] = normal;
                                end
                            end
                            default: ;
                        endcase
                    end
                end
                if (s.arr.hv && tick) begin
                    if (s.presc >= s.div - 10'h001) begin
                        n.presc = 10'h000;
                        n.hv_cnt = s.hv_cnt + 9'h001;
                        if (s.hv_cnt == 9'(HV_TICKS - 1)) begin
                            n.arr.hv = 1'b0;
                            if (s.prog[PROG_AUTO]) begin
                                n.prog[PROG_PGM] = 1'b0;
                            end
                        end
                    end else begin
                        n.presc = s.presc + 10'h001;
                    end
                end
            end
            default: n.st = ST_RUN;
        endcase
        n.arr.erase = n.prog[PROG_ERASE];
        n.arr.one_loc = n.prog[PROG_ONE_LOC];
        n.arr.row = n.prog[PROG_ROW];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.st <= ST_LD_HI;
            s.osc_s1 <= 1'b0;
            s.osc_s2 <= 1'b0;
            s.osc_s3 <= 1'b0;
            s.smn_s1 <= 1'b1;
            s.smn_s2 <= 1'b1;
            s.pready <= 1'b0;
            s.pslverr <= 1'b0;
            s.prdata <= 32'h0000_0000;
            s.mcr <= MCR_RST;
            s.prot <= PROT_RST;
            s.prog <= PROG_RST;
            s.div <= DIV_RST;
            s.div_locked <= 2'b00;
            s.presc <= 10'h000;
            s.hv_cnt <= 9'h000;
            s.arr <= '{addr: SHADOW_HI_OFS, wdata: 16'h0000, word: 1'b0,
                       shadow: 1'b1, hv: 1'b0, erase: 1'b0,
                       one_loc: 1'b0, row: 1'b0};
        end else if (ce) begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign debug_lockout_disable = s.mcr[MCR_DBG_LOCK_DIS];
    assign arr = s.arr;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_pgm_needs_latch:
        assert property (@(posedge pclk) disable iff (!presetn)
            s.prog[PROG_PGM] && !$past(s.prog[PROG_PGM])
            |-> $past(s.prog[PROG_LATCH]))
        else $error("program-enable set without prior latch");

    a_pgm_freezes_cfg:
        assert property (@(posedge pclk) disable iff (!presetn)
            $past(s.prog[PROG_PGM]) && s.prog[PROG_PGM]
            |-> $stable(s.prog[7:1]) && $stable(s.arr.addr)
                && $stable(s.arr.wdata))
        else $error("settings changed during program cycle");

    a_div_zero_block:
        assert property (@(posedge pclk) disable iff (!presetn)
            $rose(s.arr.hv) |-> $past(s.div) != 10'h000)
        else $error("cycle started with zero divider");

    a_div_write_once:
        assert property (@(posedge pclk) disable iff (!presetn)
            ce && s.div_locked == 2'b11 && s.smn_s2 && s.st == ST_RUN
            |=> $stable(s.div))
        else $error("locked divider changed");

    a_auto_clears_pgm:
        assert property (@(posedge pclk) disable iff (!presetn)
            $fell(s.arr.hv) && $past(s.prog[PROG_AUTO])
            && $past(s.hv_cnt) == 9'(HV_TICKS - 1)
            |-> !s.prog[PROG_PGM])
        else $error("auto mode left program-enable set");

    a_latch_survives:
        assert property (@(posedge pclk) disable iff (!presetn)
            $fell(s.prog[PROG_PGM]) |-> s.prog[PROG_LATCH])
        else $error("latch cleared with program-enable");

    a_shadow_hi_load:
        assert property (@(posedge pclk) disable iff (!presetn)
            ce && s.st == ST_LD_HI
            |=> s.mcr[7:4] == $past(arr_rdata[7:4])
                && s.div[9:8] == $past(arr_rdata[1:0])
                && s.st == ST_LD_LO)
        else $error("shadow high byte not loaded");

    a_shadow_lo_load:
        assert property (@(posedge pclk) disable iff (!presetn)
            ce && s.st == ST_LD_LO
            |=> s.div[7:0] == $past(arr_rdata) && s.st == ST_RUN)
        else $error("shadow low byte not loaded");

    a_hv_timer_end:
        assert property (@(posedge pclk) disable iff (!presetn)
            s.arr.hv |-> s.prog[PROG_PGM]
                && s.hv_cnt < 9'(HV_TICKS))
        else $error("high voltage outside program window");

endmodule : eeprom_ctl

//--- tb/eeprom_array_model.sv
// array model behind the eeprom controller: regular bytes plus the
// two-byte shadow row, written back when the voltage phase ends.
// assumes arr is registered by the controller on pclk.
`timescale 1ns/1ps
module eeprom_array_model
    import eeprom_ctl_pkg::*;
(
    // clock
    input wire logic pclk,
    // controller side
    input wire array_port_t arr,
    output logic [7:0] arr_rdata
);
    logic [7:0] mem [0:4095];
    logic [7:0] shadow_word [0:1];
    logic [7:0] hi;
    logic [7:0] lo;
    array_port_t cap;
    logic hv_q;

    task automatic put(input logic sh, input logic [11:0] a,
                       input logic [7:0] d);
        if (sh) begin
            shadow_word[a[0]] = d;
        end else begin
            mem[a] = d;
        end
    endtask : put

    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'hff;
        end
        // test and unused bits kept at one
        shadow_word[0] = 8'hbd;
        shadow_word[1] = 8'h23;
        hv_q = 1'b0;
    end

    assign arr_rdata = arr.shadow ? shadow_word[arr.addr[0]]
                                  : mem[arr.addr];

    always @(posedge pclk) begin
        hv_q <= arr.hv;
        if (arr.hv) begin
            cap <= arr;
        end
        if (hv_q && !arr.hv) begin
            hi = cap.erase ? 8'hff : cap.wdata[15:8];
            lo = cap.erase ? 8'hff : cap.wdata[7:0];
            if (cap.word) begin
                put(cap.shadow, {cap.addr[11:1], 1'b0}, hi);
                put(cap.shadow, {cap.addr[11:1], 1'b1}, lo);
            end else begin
                put(cap.shadow, cap.addr, lo);
            end
        end
    end
endmodule : eeprom_array_model

//--- tb/testbench.sv
// testbench for the eeprom control block: apb master tasks and
// directed sequences, array model standing behind the block.
// drives the mode pin and the clock enable through normal and special runs.
`timescale 1ns/1ps
module testbench
    import eeprom_ctl_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, osc_clk;
    logic ce, special_mode_n;
    logic pready, pslverr, dbg_dis, serr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0] pstrb;
    logic [7:0] arr_rdata;
    array_port_t arr;
    int mismatches, total_checks;

    eeprom_ctl dut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_clk(osc_clk),
        .special_mode_n(special_mode_n), .debug_lockout_disable(dbg_dis),
        .arr_rdata(arr_rdata), .arr(arr));
    eeprom_array_model mem_model (.pclk(pclk), .arr(arr),
        .arr_rdata(arr_rdata));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        osc_clk = 1'b0;
        forever #20 osc_clk = ~osc_clk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task chk(input string name, input logic [31:0] exp,
             input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
             input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", 32'h1, {31'h0, pready});
        rdata = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask : wr

    task rdc(input string name, input logic [15:0] a,
             input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(name, exp, rdata);
        chk({name, " err"}, 32'h0, {31'h0, serr});
    endtask : rdc

    function automatic logic [15:0] aa(input logic [11:0] o);
        return {2'b01, o, 2'b00};
    endfunction : aa

    task hv_run;
        int n;
        n = 0;
        while (arr.hv !== 1'b1 && n < 4) begin
            @(posedge pclk);
            n++;
        end
        chk("hv on", 32'h1, {31'h0, arr.hv});
        n = 0;
        while (arr.hv === 1'b1 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        chk("hv off", 32'h0, {31'h0, arr.hv});
    endtask : hv_run

    task prog_auto(input logic [7:0] c, input logic [11:0] o,
                   input logic [15:0] d, input logic [3:0] s);
        logic [2:0] sz;
        wr(PROG_ADDR, {24'h0, c});
        apb(1'b1, aa(o), {16'h0, d}, s);
        sz = {arr.one_loc, arr.row, arr.erase};
        chk("erase size", {29'h0, c[4:2]}, {29'h0, sz});
        wr(PROG_ADDR, {24'h0, c | 8'h01});
        hv_run;
        rdc("auto clear", PROG_ADDR, {24'h0, c});
        wr(PROG_ADDR, 32'h80);
    endtask : prog_auto

    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    initial begin
        #600000;
        mismatches++;
        final_report;
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        ce = 1'b1;
        special_mode_n = 1'b1;
        presetn = 1'b0;
        mismatches = 0;
        total_checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc("config", MCR_ADDR, 32'hbc);
        chk("dbg lockout", 32'h1, {31'h0, dbg_dis});
        rdc("div high", DIVH_ADDR, 32'h1);
        rdc("div low", DIVL_ADDR, 32'h23);
        rdc("control", PROG_ADDR, 32'h80);
        rdc("protect", PROT_ADDR, 32'hff);
        rdc("shadow hi", aa(SHADOW_HI_OFS), 32'hbd);
        rdc("shadow lo", aa(SHADOW_LO_OFS), 32'h23);
        apb(1'b0, 16'h0020, 32'h0, 4'h0);
        chk("slverr", 32'h1, {31'h0, serr});
        $display("test reset load done");
        wr(DIVH_ADDR, 32'h0);
        wr(DIVL_ADDR, 32'h1);
        wr(DIVH_ADDR, 32'h3);
        wr(DIVL_ADDR, 32'hff);
        rdc("div high", DIVH_ADDR, 32'h0);
        rdc("div low", DIVL_ADDR, 32'h1);
        $display("test divider lock done");
        wr(PROG_ADDR, 32'h83);
        rdc("control", PROG_ADDR, 32'h82);
        apb(1'b1, aa(12'h010), 32'h1234, 4'h3);
        wr(PROG_ADDR, 32'h83);
        wr(PROG_ADDR, 32'ha3);
        rdc("frozen", PROG_ADDR, 32'h83);
        apb(1'b1, aa(12'h020), 32'h55, 4'h1);
        chk("latched addr", 32'h10, {20'h0, arr.addr});
        hv_run;
        rdc("pgm held", PROG_ADDR, 32'h83);
        wr(PROG_ADDR, 32'h82);
        rdc("latch kept", PROG_ADDR, 32'h82);
        wr(PROG_ADDR, 32'h80);
        rdc("word hi", aa(12'h010), 32'h12);
        rdc("word lo", aa(12'h011), 32'h34);
        $display("test manual program done");
        prog_auto(8'ha2, 12'h020, 16'h005a, 4'h1);
        rdc("auto byte", aa(12'h020), 32'h5a);
        prog_auto(8'hb6, 12'h020, 16'h0000, 4'h1);
        rdc("erased byte", aa(12'h020), 32'hff);
        $display("test auto program done");
        mem_model.shadow_word[0] = 8'hfc;
        mem_model.shadow_word[1] = 8'h00;
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc("config", MCR_ADDR, 32'hfc);
        rdc("div high", DIVH_ADDR, 32'h0);
        rdc("div low", DIVL_ADDR, 32'h0);
        rdc("array fc0", aa(SHADOW_HI_OFS), 32'hff);
        wr(PROG_ADDR, 32'h82);
        rdc("no latch", PROG_ADDR, 32'h80);
        $display("test zero divider done");
        special_mode_n <= 1'b0;
        repeat (3) @(posedge pclk);
        wr(DIVH_ADDR, 32'h0);
        wr(DIVL_ADDR, 32'h7);
        wr(DIVL_ADDR, 32'h1);
        rdc("special div", DIVL_ADDR, 32'h1);
        wr(PROT_ADDR, 32'h7f);
        rdc("shadow unprot", PROT_ADDR, 32'h7f);
        wr(MCR_ADDR, 32'hbc);
        rdc("shadow shown", MCR_ADDR, 32'hbc);
        prog_auto(8'ha2, SHADOW_HI_OFS, 16'hfd23, 4'h3);
        rdc("shadow hi", aa(SHADOW_HI_OFS), 32'hfd);
        rdc("shadow lo", aa(SHADOW_LO_OFS), 32'h23);
        wr(PROT_ADDR, 32'hff);
        rdc("shadow prot", PROT_ADDR, 32'hff);
        $display("test special preset done");
        special_mode_n <= 1'b1;
        ce <= 1'b0;
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("ce freeze", 32'h1fc0, {19'h0, arr.shadow, arr.addr});
        ce <= 1'b1;
        rdc("config", MCR_ADDR, 32'hfc);
        rdc("div high", DIVH_ADDR, 32'h1);
        rdc("div low", DIVL_ADDR, 32'h23);
        $display("test shadow preset done");
        final_report;
    end
endmodule : testbench
